/* hdl/tpg_cycle_mon.sv */
// Period monitor for phase A of the three-phase generator.
// Assumes phase_a comes from a flip-flop on ref_clk.
`include "tpg_map.svh"

module tpg_cycle_mon
(
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic phase_a,
  output logic cycle_start,
  output logic period_ok
);

  logic prev_a;
  logic [2:0] since_rise;
  logic rise;

  assign rise = phase_a & ~prev_a;

  // Starts at phase A's reset level, so release is not taken for a rise
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
      prev_a <= `TPG_RST_PREV_A;
    else
      prev_a <= phase_a;
  end

  // Reset value wraps to 0 on the first clock, as if reset were a rise;
  // saturates at 6 so a stuck phase never looks like a good period
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
      since_rise <= `TPG_RST_SINCE;
    else if (rise)
      since_rise <= 3'h0;
    else if (since_rise != 3'h6)
      since_rise <= since_rise + 3'h1;
  end

  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
      cycle_start <= 1'b0;
    else
      cycle_start <= rise;
  end

  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
      period_ok <= 1'b0;
    else if (rise)
      period_ok <= (since_rise == `TPG_LAST_COUNT);
  end

  chk_start_pulse: assert property (
    @(posedge ref_clk) disable iff (sys_rst)
    rise |=> cycle_start ##1 !cycle_start)
    else $error("cycle_start not a one-cycle pulse after phase A rise");

endmodule

/* hdl/tpg_map.svh */
// Constants for the three-phase square-wave generator.
// Assumes one free-running clock; all state sits in that one domain.
//
// Summary of operation
// - Three equal-frequency square waves, each a third period after the last.
// - Each output completes one cycle per six input clock cycles.
// - Works at any input clock duty cycle; only rising edges matter.
// - Never stays in the parasitic 000/111 alternation after upset.
// - State 111 is decoded and forced into the legal sequence next clock.
// - All three state flip-flops share one clock edge; only one of them changes on each edge of the legal sequence.
`ifndef TPG_MAP_SVH
`define TPG_MAP_SVH

// ============================================================
// Sequence codes, bits ordered A B C
`define TPG_CODE_FIRST 3'h5
`define TPG_CODE_ONES 3'h7
`define TPG_CODE_ESCAPE 3'h4
`define TPG_CODE_ZERO 3'h0

// ============================================================
// Timing
`define TPG_DIVIDE 3'h6
`define TPG_LAST_COUNT 3'h5
`define TPG_HIGH_CYCLES 3'h3

// ============================================================
// Reset values of the period monitor
`define TPG_RST_PREV_A 1'b1
`define TPG_RST_SINCE 3'h7

`endif

/* hdl/tpg_pkg.sv */
// Types and next-state helpers for the three-phase generator.
// Assumes tpg_map.svh is on the include path.
`include "tpg_map.svh"

package tpg_pkg;

  // ============================================================
  // State encoding, bits are phase A, B, C
  typedef enum logic [2:0]
  {
    tpg_st_000 = 3'h0,
    tpg_st_001 = 3'h1,
    tpg_st_010 = 3'h2,
    tpg_st_011 = 3'h3,
    tpg_st_100 = 3'h4,
    tpg_st_101 = 3'h5,
    tpg_st_110 = 3'h6,
    tpg_st_111 = 3'h7
  } tpg_state_t;

  // ============================================================
  // Helpers
  function automatic logic tpg_is_legal(input tpg_state_t s);
    tpg_is_legal = (s != tpg_st_000) && (s != tpg_st_111);
  endfunction

  function automatic tpg_state_t tpg_advance(input tpg_state_t s);
    case (s)
      tpg_st_101: tpg_advance = tpg_st_100;
      tpg_st_100: tpg_advance = tpg_st_110;
      tpg_st_110: tpg_advance = tpg_st_010;
      tpg_st_010: tpg_advance = tpg_st_011;
      tpg_st_011: tpg_advance = tpg_st_001;
      tpg_st_001: tpg_advance = tpg_st_101;
      // Left alone, 111 would fall to 000 and back forever
      tpg_st_111: tpg_advance = tpg_state_t'(`TPG_CODE_ESCAPE);
      // 000 is let through to 111, which then escapes
      default: tpg_advance = tpg_st_111;
    endcase
  endfunction

endpackage

/* hdl/tpg_top.sv */
// Three-phase square-wave generator: divide-by-six state machine.
// Assumes ref_clk is free running; its duty cycle is of no concern.
`include "tpg_map.svh"

module tpg_top
(
  input wire logic ref_clk,
  input wire logic sys_rst,
  output logic phase_a,
  output logic phase_b,
  output logic phase_c,
  output logic seq_legal,
  output logic recovered,
  output logic cycle_start,
  output logic period_ok
);

  // ============================================================
  // State machine
  tpg_pkg::tpg_state_t state;
  tpg_pkg::tpg_state_t next_state;

  always_comb
  begin
    next_state = tpg_pkg::tpg_advance(state);
    case (state)
      // Decoding 111 cuts the parasitic loop within one clock
      tpg_pkg::tpg_st_111:
        next_state = tpg_pkg::tpg_state_t'(`TPG_CODE_ESCAPE);
      default:
        next_state = tpg_pkg::tpg_advance(state);
    endcase
  end

  // One edge-triggered register for all three phases, so skew between
  // them is only flop-to-flop and clock duty cycle cannot matter
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
      state <= tpg_pkg::tpg_state_t'(`TPG_CODE_FIRST);
    else
      state <= next_state;
  end

  // Phase outputs are the state bits themselves, no extra delay
  assign phase_a = state[2];
  assign phase_b = state[1];
  assign phase_c = state[0];

  // ============================================================
  // Status
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
      seq_legal <= 1'b1;
    else
      seq_legal <= tpg_pkg::tpg_is_legal(next_state);
  end

  // Pulses for one clock, set on the same edge as the escape from 111
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
      recovered <= 1'b0;
    else
      recovered <= (state == tpg_pkg::tpg_st_111);
  end

  // ============================================================
  // Period monitor
  tpg_cycle_mon u_cycle_mon
  (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .phase_a(phase_a),
    .cycle_start(cycle_start),
    .period_ok(period_ok)
  );

  // ============================================================
  // Checks
  default clocking tpg_cb @(posedge ref_clk);
  endclocking

  default disable iff (sys_rst);

  logic [3:0] run_len;

  // Counts clocks since the state last left 101, saturating
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
      run_len <= 4'h0;
    else if (state == tpg_pkg::tpg_st_101)
      run_len <= 4'h0;
    else if (run_len != 4'hf)
      run_len <= run_len + 4'h1;
  end

  chk_legal_step: assert property (
    tpg_pkg::tpg_is_legal(state)
    |=> state == tpg_pkg::tpg_advance($past(state)))
    else $error("legal state did not advance along the sequence");

  chk_first_step: assert property (
    state == tpg_pkg::tpg_st_101
    |=> state == tpg_pkg::tpg_st_100 ##1 state == tpg_pkg::tpg_st_110
    ##1 state == tpg_pkg::tpg_st_010 ##1 state == tpg_pkg::tpg_st_011
    ##1 state == tpg_pkg::tpg_st_001)
    else $error("sequence order broken after 101");

  chk_ones_escape: assert property (
    state == tpg_pkg::tpg_st_111 |=> state == tpg_pkg::tpg_st_100)
    else $error("111 not forced to 100 on next clock");

  chk_zero_escape: assert property (
    state == tpg_pkg::tpg_st_000
    |-> ##2 tpg_pkg::tpg_is_legal(state))
    else $error("000 not recovered within two clocks");

  chk_no_parasite: assert property (
    !tpg_pkg::tpg_is_legal(state) |-> ##[1:2] tpg_pkg::tpg_is_legal(state))
    else $error("illegal state persisted");

  chk_divide_six: assert property (
    state == tpg_pkg::tpg_st_101
    |-> ##6 state == tpg_pkg::tpg_st_101)
    else $error("period of state sequence is not six clocks");

  chk_run_bound: assert property (
    run_len <= 4'h5)
    else $error("more than six clocks without passing 101");

  chk_a_high_three: assert property (
    $rose(phase_a) |-> phase_a [*3] ##1 !phase_a [*3] ##1 phase_a)
    else $error("phase A not high three and low three clocks");

  chk_b_lags_a: assert property (
    $rose(phase_a) |-> ##2 $rose(phase_b))
    else $error("phase B not two clocks behind phase A");

  chk_c_lags_b: assert property (
    $rose(phase_b) |-> ##2 $rose(phase_c))
    else $error("phase C not two clocks behind phase B");

  chk_single_edge: assert property (
    tpg_pkg::tpg_is_legal(state) |=>
    $countones(state ^ $past(state)) == 1)
    else $error("more than one phase switched on one edge");

  chk_recover_flag: assert property (
    state == tpg_pkg::tpg_st_111 |=> recovered ##1 !recovered)
    else $error("recovered pulse missing after escape from 111");

  chk_legal_flag: assert property (
    seq_legal == tpg_pkg::tpg_is_legal(state))
    else $error("seq_legal disagrees with the state");

  chk_period_ok: assert property (
    $rose(phase_a) ##6 $rose(phase_a) |=> period_ok)
    else $error("period_ok low after a full six-clock period");

  chk_ok_held: assert property (
    !$rose(phase_a) |=> $stable(period_ok))
    else $error("period_ok changed without a rise of phase A");

  chk_start_on_rise: assert property (
    $rose(phase_a) |=> cycle_start)
    else $error("cycle_start missing after phase A rose");

  chk_start_no_rise: assert property (
    !$rose(phase_a) |=> !cycle_start)
    else $error("cycle_start without a rise of phase A");

  chk_start_spacing: assert property (
    cycle_start |=> !cycle_start [*5] ##1 cycle_start)
    else $error("cycle_start pulses not six clocks apart");

  chk_recover_cause: assert property (
    recovered == ($past(state) == tpg_pkg::tpg_st_111))
    else $error("recovered disagrees with the previous state");

  chk_stays_legal: assert property (
    tpg_pkg::tpg_is_legal(state) |=> tpg_pkg::tpg_is_legal(state))
    else $error("legal state stepped into 000 or 111");

  // ============================================================
  // Phase shapes and periods, and each phase against its neighbours
  chk_b_high_three: assert property (
    $rose(phase_b) |-> phase_b [*3] ##1 !phase_b [*3] ##1 phase_b)
    else $error("phase B not high three and low three clocks");

  chk_c_high_three: assert property (
    $rose(phase_c) |-> phase_c [*3] ##1 !phase_c [*3] ##1 phase_c)
    else $error("phase C not high three and low three clocks");

  chk_a_lags_c: assert property (
    $rose(phase_c) |-> ##2 $rose(phase_a))
    else $error("phase A not two clocks behind phase C");

  chk_a_fall_order: assert property (
    $fell(phase_c) |-> ##2 $fell(phase_a))
    else $error("phase A did not fall two clocks after phase C");

  chk_b_fall_order: assert property (
    $fell(phase_a) |-> ##2 $fell(phase_b))
    else $error("phase B did not fall two clocks after phase A");

  chk_c_fall_order: assert property (
    $fell(phase_b) |-> ##2 $fell(phase_c))
    else $error("phase C did not fall two clocks after phase B");

  chk_a_period: assert property (
    $rose(phase_a) |-> ##6 $rose(phase_a))
    else $error("phase A period is not six clocks");

  chk_b_period: assert property (
    $rose(phase_b) |-> ##6 $rose(phase_b))
    else $error("phase B period is not six clocks");

  chk_c_period: assert property (
    $rose(phase_c) |-> ##6 $rose(phase_c))
    else $error("phase C period is not six clocks");

endmodule

/* verification/three_phase_square_wave_gen_test.sv */
// Self-checking bench for the three-phase generator.
// Assumes tpg_top and the clock source model are compiled first.
module three_phase_square_wave_gen_test;
  timeunit 1ns;
  timeprecision 1ps;

  // ============================================================
  // Signals
  logic ref_clk;
  logic sys_rst = 1'b1;
  logic phase_a;
  logic phase_b;
  logic phase_c;
  logic seq_legal;
  logic recovered;
  logic cycle_start;
  logic period_ok;
  int high_ns = 10;
  int err_count = 0;
  int check_count = 0;
  int cyc = 0;
  localparam logic [2:0] SEQ [6] = '{3'h5, 3'h4, 3'h6, 3'h2, 3'h3, 3'h1};

  tpg_clk_src u_src
  (
    .high_ns(high_ns),
    .ref_clk(ref_clk)
  );

  tpg_top u_dut
  (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .phase_a(phase_a),
    .phase_b(phase_b),
    .phase_c(phase_c),
    .seq_legal(seq_legal),
    .recovered(recovered),
    .cycle_start(cycle_start),
    .period_ok(period_ok)
  );

  // ============================================================
  // Shared tasks
  task automatic check(input logic [2:0] got, input logic [2:0] exp);
    check_count++;
    if (got !== exp)
    begin
      err_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic tally_and_finish;
    $display("checks=%0d mismatches=%0d", check_count, err_count);
    if (err_count == 0 && check_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // Reset lands even in mid-sequence, so later tests restart the walk
  task automatic do_reset;
    @(posedge ref_clk);
    sys_rst <= 1'b1;
    repeat (12) @(posedge ref_clk);
    sys_rst <= 1'b0;
    #1;
    check({phase_a, phase_b, phase_c}, 3'h5);
    check({seq_legal, recovered, cycle_start}, 3'h4);
    check({2'h0, period_ok}, 3'h0);
  endtask

  // Two full output periods, every edge compared
  task automatic walk;
    logic [2:0] exp;
    for (int i = 1; i <= 13; i++)
    begin
      @(posedge ref_clk);
      #1;
      exp = SEQ[i % 6];
      check({phase_a, phase_b, phase_c}, exp);
      check({2'h0, cycle_start}, {2'h0, i % 6 == 1 && i > 1});
      check({2'h0, period_ok}, {2'h0, i > 6});
      check({1'b0, seq_legal, recovered}, 3'h2);
    end
  endtask

  // ============================================================
  // Scenarios
  task automatic test_square_clock;
    high_ns = 10;
    do_reset();
    walk();
    $display("test_square_clock done");
  endtask

  task automatic test_short_high;
    high_ns = 4;
    do_reset();
    walk();
    $display("test_short_high done");
  endtask

  task automatic test_long_high;
    high_ns = 16;
    do_reset();
    walk();
    $display("test_long_high done");
  endtask

  // ============================================================
  // Run control
  always @(posedge ref_clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 400)
    begin
      err_count++;
      tally_and_finish();
    end
  end

  initial
  begin
    test_square_clock();
    test_short_high();
    test_long_high();
    tally_and_finish();
  end
endmodule

/* verification/tpg_clk_src.sv */
// Clock source model feeding the three-phase generator.
// Assumes the bench sets the high time; the period stays 20 ns.
// ============================================================
// Clock source
module tpg_clk_src
(
  input var int high_ns,
  output logic ref_clk
);
  timeunit 1ns;
  timeprecision 1ps;

  // Uneven halves on purpose: the source owes no square wave
  initial
  begin
    ref_clk = 1'b0;
    forever
    begin
      #(20 - high_ns) ref_clk = 1'b1;
      #(high_ns) ref_clk = 1'b0;
    end
  end
endmodule
